// File: logic/pcsr_pkg.sv
// transceiver control and status register bank: offsets, fields, resets
// assumes byte offsets from the controller's csr base, 32-bit accesses only
package pcsr_pkg;

  // ----------------------------------------------------------------
  // register offsets (bytes from csr base)
  // ----------------------------------------------------------------
  localparam logic [7:0] L_OFS_PHY_CONTROL = 8'hB4;
  localparam logic [7:0] L_OFS_PHY_STATUS = 8'hB8;
  localparam logic [7:0] L_OFS_PHY_IDENT_HIGH = 8'hBC;
  localparam logic [7:0] L_OFS_PHY_IDENT_LOW = 8'hC0;
  localparam logic [7:0] L_OFS_NEGOTIATION_ADVERT = 8'hC4;
  localparam logic [7:0] L_OFS_PARTNER_ABILITY = 8'hC8;
  localparam logic [7:0] L_OFS_NEGOTIATION_EXPANSION = 8'hCC;
  localparam logic [7:0] L_OFS_PHY_MODE_CONTROL = 8'hD0;
  localparam logic [7:0] L_OFS_PHY_CONFIG_IRQ_STATUS = 8'hD4;
  localparam logic [7:0] L_OFS_PHY_IRQ_ENABLE = 8'hD8;
  localparam logic [7:0] L_OFS_FAST_PHY_CONTROL_STATUS = 8'hDC;
  localparam int L_NUM_REGS = 11;

  // ----------------------------------------------------------------
  // control register bit positions
  // ----------------------------------------------------------------
  localparam int L_CTL_PHY_SOFT_RESET = 15;
  localparam int L_CTL_PHY_LOOPBACK_SEL = 14;
  localparam int L_CTL_SPEED_SELECT = 13;
  localparam int L_CTL_NEGOTIATION_ENABLE = 12;
  localparam int L_CTL_PHY_POWER_DOWN = 11;
  localparam int L_CTL_NEGOTIATION_RESTART = 9;
  localparam int L_CTL_DUPLEX_SELECT = 8;
  localparam int L_CTL_COLLISION_TEST = 7;

  // ----------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------
  localparam int L_STS_FOUR_PAIR_ABILITY = 15;
  localparam int L_STS_FAST_FULL_ABILITY = 14;
  localparam int L_STS_FAST_HALF_ABILITY = 13;
  localparam int L_STS_TEN_FULL_ABILITY = 12;
  localparam int L_STS_TEN_HALF_ABILITY = 11;
  localparam int L_STS_NEGOTIATION_DONE = 5;
  localparam int L_STS_REMOTE_FAULT_LATCHED = 4;
  localparam int L_STS_NEGOTIATION_CAPABLE = 3;
  localparam int L_STS_LINK = 2;
  localparam int L_STS_BABBLE_DETECTED = 1;
  localparam int L_STS_MORE_REGS_FLAG = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic L_RST_PHY_SOFT_RESET = 1'b0;
  localparam logic L_RST_PHY_LOOPBACK_SEL = 1'b0;
  localparam logic L_RST_SPEED_SELECT = 1'b1;
  localparam logic L_RST_NEGOTIATION_ENABLE = 1'b1;
  localparam logic L_RST_PHY_POWER_DOWN = 1'b0;
  localparam logic L_RST_NEGOTIATION_RESTART = 1'b0;
  localparam logic L_RST_DUPLEX_SELECT = 1'b0;
  localparam logic L_RST_COLLISION_TEST = 1'b0;
  localparam logic L_RST_LATCHED_FLAG = 1'b0;
  localparam logic [15:0] L_RST_MISC = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic soft_reset;
    logic loopback;
    logic speed_100;
    logic neg_enable;
    logic power_down;
    logic neg_restart;
    logic full_duplex;
    logic collision_test;
  } pcsr_ctrl_s;

  typedef struct packed {
    logic reset_done;
    logic restart_ack;
    logic neg_done;
    logic neg_speed_100;
    logic neg_full_duplex;
    logic remote_fault;
    logic link_ok;
    logic jabber;
    logic [15:0] partner_ability;
    logic [15:0] neg_expansion;
    logic [15:0] config_irq_status;
  } pcsr_phy_in_s;

endpackage : pcsr_pkg

// File: logic/pcsr_regs.sv
// transceiver control/status register bank in the controller csr space
// assumes single-cycle csr read/write strobes synchronous to i_mclk and a
// transceiver core that pulses its done/ack inputs when work finishes
//
// How it works
// - eleven 16-bit registers sit at byte offsets b4h through dch, one word apart
// - accesses are full words; upper halfword reads zero, writes ignored
// - control bit 15 starts transceiver reset, self-clears when done
// - bit 13 picks 100 or 10 Mbps, reset 1, unused while negotiating
// - bit 12 enables negotiation, reset 1
// - bit 11 powers the transceiver down while set
// - bit 9 restarts negotiation, self-clears once restarted, reset 0
// - bit 8 picks full duplex, reset 0, unused while negotiating
// - bit 7 enables collision test, reset 0
// - status is read only; bit 15 reads 0, bits 14..11 and 3 read 1
// - status bit 5 shows negotiation complete, reset 0
// - status bit 4 latches remote fault high, cleared by status read
// - status bit 2 shows link, latches low on failure until read
// - status bit 1 latches jabber high in 10 Mbps only, read clears
// - latched flags hold from event until a status read releases them
// - status bit 0 always reads 1
`timescale 1ns/1ps

module pcsr_regs #(
  // arbitrary neutral identity values
  parameter logic [15:0] P_IDENT_HIGH = 16'h0A5A,
  parameter logic [15:0] P_IDENT_LOW = 16'h0010
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_csr_addr,
  input wire logic i_csr_wr,
  input wire logic i_csr_rd,
  input wire logic [31:0] i_csr_wdata,
  output logic [31:0] o_csr_rdata,
  input wire pcsr_pkg::pcsr_phy_in_s i_phy,
  output pcsr_pkg::pcsr_ctrl_s o_phy_ctrl
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // returns 0..10 for a mapped offset, 15 for anything else
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - pcsr_pkg::L_OFS_PHY_CONTROL;
    if (addr < pcsr_pkg::L_OFS_PHY_CONTROL ||
        addr > pcsr_pkg::L_OFS_FAST_PHY_CONTROL_STATUS ||
        addr[1:0] != 2'b00)
      reg_index = 4'hF;
    else
      reg_index = rel[5:2];
  endfunction : reg_index

  localparam logic [3:0] L_IDX_CTRL = 4'h0;
  localparam logic [3:0] L_IDX_STAT = 4'h1;
  localparam logic [3:0] L_IDX_ID_HI = 4'h2;
  localparam logic [3:0] L_IDX_ID_LO = 4'h3;
  localparam logic [3:0] L_IDX_ADV = 4'h4;
  localparam logic [3:0] L_IDX_PART = 4'h5;
  localparam logic [3:0] L_IDX_EXP = 4'h6;
  localparam logic [3:0] L_IDX_MODE = 4'h7;
  localparam logic [3:0] L_IDX_CIIS = 4'h8;
  localparam logic [3:0] L_IDX_IEN = 4'h9;
  localparam logic [3:0] L_IDX_FAST = 4'hA;

  logic [3:0] acc_idx;
  logic wr_ctrl;
  logic rd_stat;
  logic [15:0] wd;

  always_comb
  begin
    acc_idx = reg_index(i_csr_addr);
    wr_ctrl = i_csr_wr && (acc_idx == L_IDX_CTRL);
    rd_stat = i_csr_rd && (acc_idx == L_IDX_STAT);
    wd = i_csr_wdata[15:0];
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  pcsr_pkg::pcsr_ctrl_s ctrl_r;
  pcsr_pkg::pcsr_ctrl_s ctrl_nxt;

  // writing 0 to a self-clearing bit does not cancel an action under way;
  // a new request in the done cycle wins so it is not lost
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (i_phy.reset_done)
      ctrl_nxt.soft_reset = 1'b0;
    if (i_phy.restart_ack)
      ctrl_nxt.neg_restart = 1'b0;
    if (wr_ctrl)
    begin
      if (wd[pcsr_pkg::L_CTL_PHY_SOFT_RESET])
        ctrl_nxt.soft_reset = 1'b1;
      if (wd[pcsr_pkg::L_CTL_NEGOTIATION_RESTART])
        ctrl_nxt.neg_restart = 1'b1;
      ctrl_nxt.loopback = wd[pcsr_pkg::L_CTL_PHY_LOOPBACK_SEL];
      ctrl_nxt.speed_100 = wd[pcsr_pkg::L_CTL_SPEED_SELECT];
      ctrl_nxt.neg_enable = wd[pcsr_pkg::L_CTL_NEGOTIATION_ENABLE];
      ctrl_nxt.power_down = wd[pcsr_pkg::L_CTL_PHY_POWER_DOWN];
      ctrl_nxt.full_duplex = wd[pcsr_pkg::L_CTL_DUPLEX_SELECT];
      ctrl_nxt.collision_test = wd[pcsr_pkg::L_CTL_COLLISION_TEST];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      ctrl_r.soft_reset <= pcsr_pkg::L_RST_PHY_SOFT_RESET;
      ctrl_r.loopback <= pcsr_pkg::L_RST_PHY_LOOPBACK_SEL;
      ctrl_r.speed_100 <= pcsr_pkg::L_RST_SPEED_SELECT;
      ctrl_r.neg_enable <= pcsr_pkg::L_RST_NEGOTIATION_ENABLE;
      ctrl_r.power_down <= pcsr_pkg::L_RST_PHY_POWER_DOWN;
      ctrl_r.neg_restart <= pcsr_pkg::L_RST_NEGOTIATION_RESTART;
      ctrl_r.full_duplex <= pcsr_pkg::L_RST_DUPLEX_SELECT;
      ctrl_r.collision_test <= pcsr_pkg::L_RST_COLLISION_TEST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transceiver controls
  // ----------------------------------------------------------------
  pcsr_pkg::pcsr_ctrl_s phy_ctrl_r;
  pcsr_pkg::pcsr_ctrl_s phy_ctrl_nxt;

  // while negotiating, speed and duplex come from the negotiated result,
  // so the manual selections are simply not looked at
  always_comb
  begin
    phy_ctrl_nxt = ctrl_nxt;
    if (ctrl_nxt.neg_enable)
    begin
      phy_ctrl_nxt.speed_100 = i_phy.neg_speed_100;
      phy_ctrl_nxt.full_duplex = i_phy.neg_full_duplex;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      phy_ctrl_r <= '0;
    else
      phy_ctrl_r <= phy_ctrl_nxt;
  end

  assign o_phy_ctrl = phy_ctrl_r;

  // ----------------------------------------------------------------
  // latched status flags and the live negotiation done bit
  // ----------------------------------------------------------------
  logic rf_r;
  logic rf_nxt;
  logic link_r;
  logic link_nxt;
  logic jab_r;
  logic jab_nxt;
  logic done_r;
  logic done_nxt;

  // a read releases the latch and the same cycle's live state is taken,
  // so an event coinciding with the clearing read is kept
  always_comb
  begin
    rf_nxt = (rd_stat ? 1'b0 : rf_r) | i_phy.remote_fault;
    link_nxt = (rd_stat ? 1'b1 : link_r) & i_phy.link_ok;
    jab_nxt = (rd_stat ? 1'b0 : jab_r) |
              (i_phy.jabber & ~phy_ctrl_r.speed_100);
    done_nxt = i_phy.neg_done & ctrl_r.neg_enable;
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      rf_r <= pcsr_pkg::L_RST_LATCHED_FLAG;
      link_r <= pcsr_pkg::L_RST_LATCHED_FLAG;
      jab_r <= pcsr_pkg::L_RST_LATCHED_FLAG;
      done_r <= pcsr_pkg::L_RST_LATCHED_FLAG;
    end
    else
    begin
      rf_r <= rf_nxt;
      link_r <= link_nxt;
      jab_r <= jab_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // plain storage for the remaining writable registers
  // ----------------------------------------------------------------
  localparam int L_NUM_MISC = 4;
  logic [15:0] misc_r [L_NUM_MISC];
  logic [15:0] misc_nxt [L_NUM_MISC];
  logic [1:0] misc_sel;
  logic misc_hit;

  always_comb
  begin
    misc_hit = 1'b1;
    case (acc_idx)
      L_IDX_ADV: misc_sel = 2'h0;
      L_IDX_MODE: misc_sel = 2'h1;
      L_IDX_IEN: misc_sel = 2'h2;
      L_IDX_FAST: misc_sel = 2'h3;
      default:
      begin
        misc_sel = 2'h0;
        misc_hit = 1'b0;
      end
    endcase
    for (int k = 0; k < L_NUM_MISC; k++)
      misc_nxt[k] = misc_r[k];
    if (i_csr_wr && misc_hit)
      misc_nxt[misc_sel] = wd;
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      for (int k = 0; k < L_NUM_MISC; k++)
        misc_r[k] <= pcsr_pkg::L_RST_MISC;
    end
    else
    begin
      for (int k = 0; k < L_NUM_MISC; k++)
        misc_r[k] <= misc_nxt[k];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;
  logic [15:0] rd_word;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb
  begin
    ctrl_view = 16'h0000;
    ctrl_view[pcsr_pkg::L_CTL_PHY_SOFT_RESET] = ctrl_r.soft_reset;
    ctrl_view[pcsr_pkg::L_CTL_PHY_LOOPBACK_SEL] = ctrl_r.loopback;
    ctrl_view[pcsr_pkg::L_CTL_SPEED_SELECT] = ctrl_r.speed_100;
    ctrl_view[pcsr_pkg::L_CTL_NEGOTIATION_ENABLE] = ctrl_r.neg_enable;
    ctrl_view[pcsr_pkg::L_CTL_PHY_POWER_DOWN] = ctrl_r.power_down;
    ctrl_view[pcsr_pkg::L_CTL_NEGOTIATION_RESTART] = ctrl_r.neg_restart;
    ctrl_view[pcsr_pkg::L_CTL_DUPLEX_SELECT] = ctrl_r.full_duplex;
    ctrl_view[pcsr_pkg::L_CTL_COLLISION_TEST] = ctrl_r.collision_test;

    stat_view = 16'h0000;
    stat_view[pcsr_pkg::L_STS_FOUR_PAIR_ABILITY] = 1'b0;
    stat_view[pcsr_pkg::L_STS_FAST_FULL_ABILITY] = 1'b1;
    stat_view[pcsr_pkg::L_STS_FAST_HALF_ABILITY] = 1'b1;
    stat_view[pcsr_pkg::L_STS_TEN_FULL_ABILITY] = 1'b1;
    stat_view[pcsr_pkg::L_STS_TEN_HALF_ABILITY] = 1'b1;
    stat_view[pcsr_pkg::L_STS_NEGOTIATION_DONE] = done_r;
    stat_view[pcsr_pkg::L_STS_REMOTE_FAULT_LATCHED] = rf_r;
    stat_view[pcsr_pkg::L_STS_NEGOTIATION_CAPABLE] = 1'b1;
    stat_view[pcsr_pkg::L_STS_LINK] = link_r;
    stat_view[pcsr_pkg::L_STS_BABBLE_DETECTED] = jab_r;
    stat_view[pcsr_pkg::L_STS_MORE_REGS_FLAG] = 1'b1;

    case (acc_idx)
      L_IDX_CTRL: rd_word = ctrl_view;
      L_IDX_STAT: rd_word = stat_view;
      L_IDX_ID_HI: rd_word = P_IDENT_HIGH;
      L_IDX_ID_LO: rd_word = P_IDENT_LOW;
      L_IDX_PART: rd_word = i_phy.partner_ability;
      L_IDX_EXP: rd_word = i_phy.neg_expansion;
      L_IDX_CIIS: rd_word = i_phy.config_irq_status;
      L_IDX_ADV,
      L_IDX_MODE,
      L_IDX_IEN,
      L_IDX_FAST: rd_word = misc_r[misc_sel];
      default: rd_word = 16'h0000;
    endcase

    rdata_nxt = rdata_r;
    if (i_csr_rd)
      rdata_nxt = {16'h0000, rd_word};
  end

  always_ff @(posedge i_mclk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  assign o_csr_rdata = rdata_r;

endmodule : pcsr_regs

// File: dv/pcsr_regs_asserts.sv
// checker for the transceiver control/status register bank
// assumes it is bound to pcsr_regs and sees only that module's ports
`timescale 1ns/1ps

module pcsr_regs_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_csr_addr,
  input wire logic i_csr_wr,
  input wire logic i_csr_rd,
  input wire logic [31:0] i_csr_wdata,
  input wire logic [31:0] o_csr_rdata,
  input wire pcsr_pkg::pcsr_phy_in_s i_phy,
  input wire pcsr_pkg::pcsr_ctrl_s o_phy_ctrl
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // internal reset lags the pin by two flops, so judge only once settled
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  logic rdy;
  logic rd_sts;
  logic wr_ctl;
  logic unm;
  assign rdy = up_r == 2'h3;
  assign rd_sts = i_csr_rd && i_csr_addr == pcsr_pkg::L_OFS_PHY_STATUS;
  assign wr_ctl = i_csr_wr && i_csr_addr == pcsr_pkg::L_OFS_PHY_CONTROL;
  assign unm = i_csr_addr < 8'hB4 || i_csr_addr > 8'hDC
    || i_csr_addr[1:0] != 2'h0;
  always_comb
  begin
    up_nxt = rdy ? up_r : up_r + 2'h1;
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      up_r <= 2'h0;
    else
      up_r <= up_nxt;
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_ctl_wr;
    rdy && wr_ctl ##1 !i_csr_wr;
  endsequence
  sequence s_quiet_neg;
    rdy && o_phy_ctrl.neg_enable && !i_csr_wr ##1 !i_csr_wr;
  endsequence
  property p_upper;
    o_csr_rdata[31:16] == 16'h0000;
  endproperty
  property p_fixed;
    rdy && rd_sts |=> o_csr_rdata[15:6] == 10'h1E0 && o_csr_rdata[3]
      && o_csr_rdata[0];
  endproperty
  property p_ctl_rsvd;
    rdy && i_csr_rd && i_csr_addr == pcsr_pkg::L_OFS_PHY_CONTROL
      |=> !o_csr_rdata[10] && o_csr_rdata[6:0] == 7'h00;
  endproperty
  property p_unmapped;
    rdy && i_csr_rd && unm |=> o_csr_rdata == 32'h00000000;
  endproperty
  property p_ctl_wr;
    s_ctl_wr |=> o_phy_ctrl.loopback == $past(i_csr_wdata[14], 2)
      && o_phy_ctrl.neg_enable == $past(i_csr_wdata[12], 2)
      && o_phy_ctrl.power_down == $past(i_csr_wdata[11], 2)
      && o_phy_ctrl.collision_test == $past(i_csr_wdata[7], 2)
      && (o_phy_ctrl.neg_enable
      || (o_phy_ctrl.speed_100 == $past(i_csr_wdata[13], 2)
      && o_phy_ctrl.full_duplex == $past(i_csr_wdata[8], 2)));
  endproperty
  property p_neg_follow;
    s_quiet_neg ##0 $stable(i_phy.neg_speed_100)
      && $stable(i_phy.neg_full_duplex)
      |=> o_phy_ctrl.speed_100 == $past(i_phy.neg_speed_100)
      && o_phy_ctrl.full_duplex == $past(i_phy.neg_full_duplex);
  endproperty
  property p_sr_hold;
    rdy && o_phy_ctrl.soft_reset && !i_phy.reset_done
      && !$past(i_phy.reset_done) |=> o_phy_ctrl.soft_reset;
  endproperty
  property p_sr_clear;
    rdy && o_phy_ctrl.soft_reset && i_phy.reset_done && !i_csr_wr
      |-> ##[1:2] !o_phy_ctrl.soft_reset;
  endproperty
  property p_rs_clear;
    rdy && o_phy_ctrl.neg_restart && i_phy.restart_ack && !i_csr_wr
      |-> ##[1:2] !o_phy_ctrl.neg_restart;
  endproperty
  property p_latch;
    rdy && !i_phy.link_ok && i_phy.remote_fault ##1 rd_sts
      |=> !o_csr_rdata[2] && o_csr_rdata[4];
  endproperty
  property p_jab;
    rdy && i_phy.jabber && !o_phy_ctrl.speed_100 ##1 rd_sts
      |=> o_csr_rdata[1];
  endproperty
  property p_release;
    rdy && rd_sts && i_phy.link_ok && !i_phy.remote_fault
      ##1 i_phy.link_ok && !i_phy.remote_fault && !i_csr_rd
      ##1 rd_sts && i_phy.link_ok && !i_phy.remote_fault
      |=> o_csr_rdata[2] && !o_csr_rdata[4];
  endproperty
  property p_done;
    s_quiet_neg ##0 rd_sts && $stable(i_phy.neg_done)
      |=> o_csr_rdata[5] == $past(i_phy.neg_done);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read half not zero");
  a_fixed: assert property (p_fixed)
    else $error("status fixed bits wrong");
  a_ctl_rsvd: assert property (p_ctl_rsvd)
    else $error("control reserved bits not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_ctl_wr: assert property (p_ctl_wr)
    else $error("control write not applied");
  a_neg_follow: assert property (p_neg_follow)
    else $error("negotiated speed or duplex not used");
  a_sr_hold: assert property (p_sr_hold)
    else $error("soft reset dropped early");
  a_sr_clear: assert property (p_sr_clear)
    else $error("soft reset not self cleared");
  a_rs_clear: assert property (p_rs_clear)
    else $error("restart not self cleared");
  a_latch: assert property (p_latch)
    else $error("latched flag lost");
  a_jab: assert property (p_jab)
    else $error("jabber not latched");
  a_release: assert property (p_release)
    else $error("flag not released to live state");
  a_done: assert property (p_done)
    else $error("negotiation done bit wrong");
endmodule : pcsr_regs_asserts

bind pcsr_regs pcsr_regs_asserts i_asserts (.i_mclk(i_mclk),
  .i_rst_n(i_rst_n), .i_csr_addr(i_csr_addr), .i_csr_wr(i_csr_wr),
  .i_csr_rd(i_csr_rd), .i_csr_wdata(i_csr_wdata),
  .o_csr_rdata(o_csr_rdata), .i_phy(i_phy), .o_phy_ctrl(o_phy_ctrl));

// File: dv/test_pcsr_regs.sv
// self-checking bench for the transceiver control/status register bank
// assumes the checker is bound in; inputs change on the falling edge
`timescale 1ns/1ps

module test_pcsr_regs;
  localparam logic [7:0] L_CTL = pcsr_pkg::L_OFS_PHY_CONTROL;
  localparam logic [7:0] L_STS = pcsr_pkg::L_OFS_PHY_STATUS;
  localparam logic [7:0] L_ST [4] = '{8'hC4, 8'hD0, 8'hD8, 8'hDC};
  logic i_mclk;
  logic i_rst_n;
  logic [7:0] addr;
  logic wr_en;
  logic rd_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  pcsr_pkg::pcsr_phy_in_s phy;
  pcsr_pkg::pcsr_ctrl_s ctrl;
  int miscompares;
  int checks;
  logic [31:0] rv;
  logic [7:0] a;

  pcsr_regs #(.P_IDENT_HIGH(16'h1234), .P_IDENT_LOW(16'h5678)) i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_csr_addr(addr),
    .i_csr_wr(wr_en), .i_csr_rd(rd_en), .i_csr_wdata(wdata),
    .o_csr_rdata(rdata), .i_phy(phy), .o_phy_ctrl(ctrl));

  // ----------------------------------------------------------------
  // bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(negedge i_mclk);
    addr = ad;
    wdata = d;
    wr_en = 1'b1;
    @(negedge i_mclk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(negedge i_mclk);
    addr = ad;
    rd_en = 1'b1;
    @(negedge i_mclk);
    rd_en = 1'b0;
    d = rdata;
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] e,
    input string nm);
    logic [31:0] g;
    rd(ad, g);
    chk(nm, e, g);
  endtask : rdchk

  function automatic logic [31:0] sts(logic dn, rf, lk, jb);
    sts = {16'h0000, 10'h1E0, dn, rf, 1'b1, lk, jb, 1'b1};
  endfunction : sts

  function automatic pcsr_pkg::pcsr_ctrl_s exp_ctl(logic [31:0] d);
    exp_ctl = '0;
    exp_ctl.loopback = d[14];
    exp_ctl.neg_enable = d[12];
    exp_ctl.power_down = d[11];
    exp_ctl.collision_test = d[7];
    exp_ctl.speed_100 = d[12] ? d[16] : d[13];
    exp_ctl.full_duplex = d[12] ? d[17] : d[8];
  endfunction : exp_ctl

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    miscompares = 0;
    checks = 0;
    i_rst_n = 1'b0;
    addr = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 32'h00000000;
    phy = '0;
    phy.link_ok = 1'b1;
    rv = $urandom(5);
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    rdchk(L_CTL, 32'h00003000, "ctrl reset");
    phy.partner_ability = 16'($urandom);
    phy.neg_expansion = 16'($urandom);
    phy.config_irq_status = 16'($urandom);
    rdchk(8'hBC, 32'h00001234, "ident high");
    rdchk(8'hC0, 32'h00005678, "ident low");
    rdchk(8'hC8, {16'h0000, phy.partner_ability}, "partner");
    rdchk(8'hCC, {16'h0000, phy.neg_expansion}, "expansion");
    rdchk(8'hD4, {16'h0000, phy.config_irq_status}, "irq sts");
    foreach (L_ST[i])
    begin
      rv = $urandom;
      wr(L_ST[i], rv);
      rdchk(L_ST[i], {16'h0000, rv[15:0]}, "storage");
    end
    for (int i = 0; i < 24; i++)
    begin
      a = (i == 0) ? 8'hB6 : (i == 1) ? 8'hE0 : 8'($urandom);
      if (a < 8'hB4 || a > 8'hDC || a[1:0] != 2'h0)
      begin
        wr(a, 32'hFFFFFFFF);
        rdchk(a, 32'h00000000, "unmapped");
      end
    end
    wr(L_STS, 32'hFFFFFFFF);
    rdchk(L_CTL, 32'h00003000, "ctrl kept");
    rd(L_STS, rv);
    rdchk(L_STS, sts(1'b0, 1'b0, 1'b1, 1'b0), "status");
    for (int i = 0; i < 10; i++)
    begin
      rv = (i == 0) ? 32'hFFFF0000 : $urandom & 32'hFFFF7DFF;
      phy.neg_speed_100 = rv[16];
      phy.neg_full_duplex = rv[17];
      // operating mode field sits outside this block; taken as 00 here
      wr(L_CTL, rv);
      rdchk(L_CTL, {16'h0000, rv[15:0] & 16'h7980}, "ctrl rw");
      chk("ctrl out", {24'h0, exp_ctl(rv)}, {24'h0, ctrl});
    end
    for (int b = 0; b < 2; b++)
    begin
      rv = b ? 32'h00000200 : 32'h00008000;
      wr(L_CTL, rv);
      wr(L_CTL, 32'h00000000);
      rdchk(L_CTL, rv, "pending");
      @(negedge i_mclk);
      phy.restart_ack = b[0];
      phy.reset_done = !b[0];
      @(negedge i_mclk);
      phy.restart_ack = 1'b0;
      phy.reset_done = 1'b0;
      rdchk(L_CTL, 32'h00000000, "self clear");
    end
    rd(L_STS, rv);
    for (int s = 0; s < 2; s++)
    begin
      // ctrl 0 runs at 10 Mbps, 2000h at 100 Mbps where jabber is ignored
      wr(L_CTL, s ? 32'h00002000 : 32'h00000000);
      phy.link_ok = 1'b0;
      phy.remote_fault = 1'b1;
      phy.jabber = 1'b1;
      rdchk(L_STS, sts(1'b0, 1'b1, 1'b0, !s), "latched");
      phy.link_ok = 1'b1;
      phy.remote_fault = 1'b0;
      phy.jabber = 1'b0;
      rdchk(L_STS, sts(1'b0, 1'b1, 1'b0, !s), "held");
      rdchk(L_STS, sts(1'b0, 1'b0, 1'b1, 1'b0), "released");
    end
    wr(L_CTL, 32'h00001000);
    phy.neg_done = 1'b1;
    rdchk(L_STS, sts(1'b1, 1'b0, 1'b1, 1'b0), "neg done");
    phy.neg_done = 1'b0;
    rdchk(L_STS, sts(1'b0, 1'b0, 1'b1, 1'b0), "neg busy");
    print_verdict();
  end
endmodule : test_pcsr_regs
